// >>> design/pcu_channel.sv
// One modulation channel: selected clock, counter, period and duty with update.
// Assumes the top gives one-cycle command pulses on the single clock.
//
// Added by the designer: the address-and-strobe port and the register addresses.
`include "pcu_map.svh"
module pcu_channel (
    // Clock and reset
    input  wire logic clock,
    input  wire logic rst,
    // Register traffic
    pcu_reg_if.chan   rif
);
    typedef struct packed {
        pcu_pkg::pcu_state_type st;
        logic [`PCU_DATA_W-1:0] pre;
        logic                   tick_seen;
        logic                   active;
        logic                   out_en;
        logic                   out;
        logic                   upd_pend;
        logic                   upd_duty;
        logic [`PCU_DATA_W-1:0] upd_val;
        logic [`PCU_DATA_W-1:0] cnt;
        logic [`PCU_DATA_W-1:0] period;
        logic [`PCU_DATA_W-1:0] duty;
    } pcu_ch_type;

    pcu_ch_type s_r;
    pcu_ch_type s_nxt;
    logic       tick;
    logic       end_per;
    logic       low_cnt;
    logic [`PCU_DATA_W-1:0] pre_top;

    always_comb begin
        // The divider is as wide as the counter so that every prescale code up to 15 gets its full rate.
        pre_top = `PCU_CNT_ONE << rif.prescale;
        tick    = (s_r.pre == pre_top - `PCU_CNT_ONE);
        end_per = tick && (s_r.cnt >= s_r.period);
        low_cnt = (s_r.cnt == `PCU_CNT_ZERO) || (s_r.cnt == `PCU_CNT_ONE);
        s_nxt   = s_r;
        s_nxt.pre = tick ? `PCU_CNT_ZERO : s_r.pre + `PCU_CNT_ONE;
        if (rif.period_wr) begin
            s_nxt.period = rif.wdata;
        end
        if (rif.duty_wr) begin
            s_nxt.duty = rif.wdata;
        end
        if (rif.update_wr) begin
            // RQ1 direct overwrite window
            if (low_cnt) begin
                // RQ3 no period update at zero
                if (!rif.upd_duty_sel && s_r.period != `PCU_CNT_ZERO) begin
                    s_nxt.period = rif.wdata;
                end
                if (rif.upd_duty_sel) begin
                    s_nxt.duty = rif.wdata;
                end
                s_nxt.upd_pend = 1'b0;
            end else begin
                s_nxt.upd_pend = 1'b1;
                s_nxt.upd_duty = rif.upd_duty_sel;
                s_nxt.upd_val  = rif.wdata;
            end
        end
        case (s_r.st)
            pcu_pkg::PCU_IDLE: begin
                s_nxt.out = 1'b0;
                if (rif.enable_cmd) begin
                    // RQ5 first period from zero
                    s_nxt.st        = pcu_pkg::PCU_FIRST;
                    s_nxt.cnt       = `PCU_CNT_ZERO;
                    s_nxt.pre       = `PCU_CNT_ZERO;
                    s_nxt.tick_seen = 1'b0;
                    s_nxt.active    = 1'b1;
                    s_nxt.out_en    = 1'b1;
                end
            end
            default: begin
                if (tick) begin
                    s_nxt.tick_seen = 1'b1;
                    s_nxt.cnt       = s_r.cnt + `PCU_CNT_ONE;
                end
                if (end_per) begin
                    // RQ5 later periods from one
                    s_nxt.st  = pcu_pkg::PCU_RUN;
                    s_nxt.cnt = `PCU_CNT_ONE;
                    // RQ11 update at period end
                    if (s_r.upd_pend && !(rif.update_wr && low_cnt)) begin
                        // A new update written in this very cycle stays pending for the next period end.
                        s_nxt.upd_pend = rif.update_wr;
                        if (s_r.upd_duty) begin
                            s_nxt.duty = s_r.upd_val;
                        end else if (s_r.period != `PCU_CNT_ZERO) begin
                            // RQ3 period update blocked
                            s_nxt.period = s_r.upd_val;
                        end
                    end
                end
                // RQ7 duty sets the high span, or the low span when polarity is set
                s_nxt.out = s_r.out_en && ((s_r.cnt < s_r.duty) ^ rif.polarity);
                if (rif.disable_cmd) begin
                    s_nxt.st     = pcu_pkg::PCU_IDLE;
                    s_nxt.out_en = 1'b0;
                    s_nxt.out    = 1'b0;
                    // RQ9 early disable keeps flag
                    // RQ11 flag follows enable
                    s_nxt.active = !(s_r.tick_seen || tick);
                end
            end
        endcase
    end

    always_ff @(posedge clock) begin
        if (rst) begin
            s_r           <= '0;
            s_r.st        <= pcu_pkg::PCU_IDLE;
            s_r.period    <= `PCU_RST_PERIOD;
            s_r.duty      <= `PCU_RST_DUTY;
        end else begin
            s_r <= s_nxt;
        end
    end

    assign rif.active    = s_r.active;
    assign rif.out_level = s_r.out;
    assign rif.count     = s_r.cnt;
    assign rif.period    = s_r.period;
    assign rif.duty      = s_r.duty;

    // RQ5 start values checked
    a_first_start: assert property (@(posedge clock) disable iff (rst)
        (s_r.st == pcu_pkg::PCU_IDLE && rif.enable_cmd) |=> s_r.cnt == `PCU_CNT_ZERO) // RQ5
        else $error("first period does not start at zero");
    a_next_start: assert property (@(posedge clock) disable iff (rst)
        (s_r.st != pcu_pkg::PCU_IDLE && end_per && !rif.disable_cmd) |=> s_r.cnt == `PCU_CNT_ONE) // RQ5
        else $error("later period does not start at one");
    a_direct_update: assert property (@(posedge clock) disable iff (rst)
        (rif.update_wr && low_cnt && rif.upd_duty_sel && !rif.duty_wr) |=> s_r.duty == $past(rif.wdata)) // RQ1
        else $error("low count update not direct");
    a_period_hold: assert property (@(posedge clock) disable iff (rst)
        (s_r.period == `PCU_CNT_ZERO && !rif.period_wr) |=> s_r.period == `PCU_CNT_ZERO) // RQ3
        else $error("zero period was updated");
    a_deferred_upd: assert property (@(posedge clock) disable iff (rst)
        (rif.update_wr && !low_cnt && !end_per && !rif.period_wr && !rif.duty_wr)
        |=> $stable(s_r.period) && $stable(s_r.duty)) // RQ11
        else $error("update took effect mid period");
    a_early_dis: assert property (@(posedge clock) disable iff (rst)
        (s_r.st == pcu_pkg::PCU_FIRST && !s_r.tick_seen && !tick && rif.disable_cmd)
        |=> s_r.active && !s_r.out_en ##1 !s_r.out) // RQ9
        else $error("early disable flag wrong");
    a_late_dis: assert property (@(posedge clock) disable iff (rst)
        (s_r.st != pcu_pkg::PCU_IDLE && s_r.tick_seen && rif.disable_cmd) |=> !s_r.active) // RQ11
        else $error("flag stuck after disable");
    a_idle_low: assert property (@(posedge clock) disable iff (rst)
        (s_r.st == pcu_pkg::PCU_IDLE) [*2] |-> !s_r.out) // RQ9
        else $error("idle channel drives output");
    c_early_dis: cover property (@(posedge clock) disable iff (rst)
        s_r.st == pcu_pkg::PCU_FIRST && !s_r.tick_seen && rif.disable_cmd);
    c_period_end: cover property (@(posedge clock) disable iff (rst) end_per && s_r.upd_pend);
    c_direct: cover property (@(posedge clock) disable iff (rst) rif.update_wr && low_cnt);
endmodule : pcu_channel

// >>> design/pcu_map.svh
// Register offsets, field positions, reset values and counts of the channel logic.
// Assumes it is included by every design file that needs a number.
`ifndef PCU_MAP_SVH
`define PCU_MAP_SVH
`define PCU_ADDR_W        4
`define PCU_DATA_W        16
`define PCU_CHANNELS      4
`define PCU_CH_W          2
`define PCU_OFS_ENABLE    4'h0
`define PCU_OFS_DISABLE   4'h1
`define PCU_OFS_STATE     4'h2
`define PCU_OFS_SELECT    4'h3
`define PCU_OFS_PERIOD    4'h4
`define PCU_OFS_DUTY      4'h5
`define PCU_OFS_UPDATE    4'h6
`define PCU_OFS_COUNT     4'h7
`define PCU_OFS_MODE      4'h8
`define PCU_OFS_OUT       4'h9
`define PCU_SEL_CH_LSB    0
`define PCU_SEL_CH_MSB    1
`define PCU_MODE_UPD_BIT  0
`define PCU_MODE_POL_BIT  1
`define PCU_MODE_PRE_LSB  4
`define PCU_MODE_PRE_MSB  7
`define PCU_RST_PERIOD    16'h0010
`define PCU_RST_DUTY      16'h0008
`define PCU_RST_PRE       4'h0
`define PCU_CNT_ONE       16'h0001
`define PCU_CNT_ZERO      16'h0000
`define PCU_PRE_ONE       8'h01
`endif

// >>> design/pcu_pkg.sv
// Types shared by the channel logic.
// Assumes pcu_map.svh is compiled alongside.
`include "pcu_map.svh"
package pcu_pkg;
    typedef enum logic [1:0] {
        PCU_IDLE  = 2'b00,
        PCU_FIRST = 2'b01,
        PCU_RUN   = 2'b10
    } pcu_state_type;
endpackage : pcu_pkg

// >>> design/pcu_reg_if.sv
// Carries one channel's register traffic from the top to a channel.
// Assumes one clock shared by both ends.
`include "pcu_map.svh"
interface pcu_reg_if;
    logic                   enable_cmd;
    logic                   disable_cmd;
    logic                   period_wr;
    logic                   duty_wr;
    logic                   update_wr;
    logic                   upd_duty_sel;
    logic                   polarity;
    logic [3:0]             prescale;
    logic [`PCU_DATA_W-1:0] wdata;
    logic                   active;
    logic                   out_level;
    logic [`PCU_DATA_W-1:0] count;
    logic [`PCU_DATA_W-1:0] period;
    logic [`PCU_DATA_W-1:0] duty;
    modport top (output enable_cmd, disable_cmd, period_wr, duty_wr, update_wr, upd_duty_sel,
                 polarity, prescale, wdata, input active, out_level, count, period, duty);
    modport chan (input enable_cmd, disable_cmd, period_wr, duty_wr, update_wr, upd_duty_sel,
                  polarity, prescale, wdata, output active, out_level, count, period, duty);
endinterface : pcu_reg_if

// >>> design/pcu_top.sv
// Top of the modulation block: register port, channels, pin outputs.
// Assumes a master driving one-cycle strobes on the same clock.
`include "pcu_map.svh"
// Contract
// RQ1 - Update write at counter 0 or 1 overwrites period or duty at once.
// RQ2 - Software reads the counter before writing the update register.
// RQ3 - With period register zero, period update through update register is skipped.
// RQ4 - Software never writes zero into the period register.
// RQ5 - Left-aligned counter starts at 0 first period, 1 in later ones.
// RQ6 - Software never writes zero into the duty register.
// RQ7 - Duty zero would mean a constant level, not a waveform.
// RQ8 - For constant levels software disables channel and uses a general pin.
// RQ9 - Disable within first selected-clock period kills output, active flag stays 1.
// RQ10 - Software waits one selected-clock period before disabling a channel.
// RQ11 - Normally updates land at period end; active flag follows enable state.
module pcu_top (
    // Clock and reset
    input  wire logic                          clock,
    input  wire logic                          rst,
    // Register port
    input  wire logic [`PCU_ADDR_W-1:0]        addr,
    input  wire logic [`PCU_DATA_W-1:0]        wdata,
    input  wire logic                          wr,
    input  wire logic                          rd,
    output logic      [`PCU_DATA_W-1:0]        rdata,
    // Modulated pins
    output logic      [`PCU_CHANNELS-1:0]      pwm_out
);
    typedef struct packed {
        logic [`PCU_CH_W-1:0]    sel;
        logic [`PCU_CHANNELS-1:0] upd_duty;
        logic [`PCU_CHANNELS-1:0] pol;
        logic [3:0]              pre;
        logic [`PCU_DATA_W-1:0]  rdata;
        logic [`PCU_CHANNELS-1:0] pins;
    } pcu_top_type;

    pcu_top_type s_r;
    pcu_top_type s_nxt;
    logic [`PCU_CHANNELS-1:0] act_v;
    logic [`PCU_CHANNELS-1:0] out_v;
    logic [`PCU_DATA_W-1:0]   cnt_v [`PCU_CHANNELS];
    logic [`PCU_DATA_W-1:0]   per_v [`PCU_CHANNELS];
    logic [`PCU_DATA_W-1:0]   dty_v [`PCU_CHANNELS];

    for (genvar i = 0; i < `PCU_CHANNELS; i++) begin : g_ch
        pcu_reg_if rif ();
        logic hit;
        assign hit                = (s_r.sel == `PCU_CH_W'(i));
        assign rif.enable_cmd     = wr && addr == `PCU_OFS_ENABLE && wdata[i];
        assign rif.disable_cmd    = wr && addr == `PCU_OFS_DISABLE && wdata[i];
        assign rif.period_wr      = wr && addr == `PCU_OFS_PERIOD && hit;
        assign rif.duty_wr        = wr && addr == `PCU_OFS_DUTY && hit;
        assign rif.update_wr      = wr && addr == `PCU_OFS_UPDATE && hit;
        assign rif.upd_duty_sel   = s_r.upd_duty[i];
        assign rif.polarity       = s_r.pol[i];
        assign rif.prescale       = s_r.pre;
        assign rif.wdata          = wdata;
        assign act_v[i]           = rif.active;
        assign out_v[i]           = rif.out_level;
        assign cnt_v[i]           = rif.count;
        assign per_v[i]           = rif.period;
        assign dty_v[i]           = rif.duty;
        pcu_channel u_ch (
            .clock (clock),
            .rst   (rst),
            .rif   (rif)
        );
    end

    always_comb begin
        s_nxt       = s_r;
        s_nxt.pins  = out_v;
        s_nxt.rdata = '0;
        if (wr) begin
            if (addr == `PCU_OFS_SELECT) begin
                s_nxt.sel = wdata[`PCU_SEL_CH_MSB:`PCU_SEL_CH_LSB];
            end else if (addr == `PCU_OFS_MODE) begin
                s_nxt.upd_duty[s_r.sel] = wdata[`PCU_MODE_UPD_BIT];
                s_nxt.pol[s_r.sel]      = wdata[`PCU_MODE_POL_BIT];
                s_nxt.pre               = wdata[`PCU_MODE_PRE_MSB:`PCU_MODE_PRE_LSB];
            end
        end
        if (rd) begin
            // RQ9 status shows active flags
            if (addr == `PCU_OFS_STATE) begin
                s_nxt.rdata = `PCU_DATA_W'(act_v);
            end else if (addr == `PCU_OFS_SELECT) begin
                s_nxt.rdata = `PCU_DATA_W'(s_r.sel);
            end else if (addr == `PCU_OFS_PERIOD) begin
                s_nxt.rdata = per_v[s_r.sel];
            end else if (addr == `PCU_OFS_DUTY) begin
                s_nxt.rdata = dty_v[s_r.sel];
            end else if (addr == `PCU_OFS_COUNT) begin
                s_nxt.rdata = cnt_v[s_r.sel];
            end else if (addr == `PCU_OFS_MODE) begin
                s_nxt.rdata = {8'h00, s_r.pre, 2'b00, s_r.pol[s_r.sel], s_r.upd_duty[s_r.sel]};
            end else if (addr == `PCU_OFS_OUT) begin
                s_nxt.rdata = `PCU_DATA_W'(s_r.pins);
            end
        end
    end

    always_ff @(posedge clock) begin
        if (rst) begin
            s_r     <= '0;
            s_r.pre <= `PCU_RST_PRE;
        end else begin
            s_r <= s_nxt;
        end
    end

    assign rdata   = s_r.rdata;
    assign pwm_out = s_r.pins;

    a_read_state: assert property (@(posedge clock) disable iff (rst)
        (rd && addr == `PCU_OFS_STATE) |=> rdata == `PCU_DATA_W'($past(act_v))) // RQ11
        else $error("state read mismatch");
    a_read_idle: assert property (@(posedge clock) disable iff (rst)
        !rd |=> rdata == '0) // RQ11
        else $error("read data not zero without read");
    c_any_out: cover property (@(posedge clock) disable iff (rst) |pwm_out);
endmodule : pcu_top

// >>> tb/pcu_load.sv
// Load model on the modulated pins: reports each finished period of a watched channel.
// Assumes registered pins on the bench clock and one watched channel at a time.
module pcu_load (
    // Clock and reset
    input  wire logic        clock,
    input  wire logic        rst,
    // Pins and watch mask
    input  wire logic [3:0]  pwm,
    input  wire logic [3:0]  watch,
    // Measured period: channel, length, high cycles
    output logic             meas_valid,
    output logic      [33:0] meas
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [15:0] len_r [4];
    logic [15:0] hi_r  [4];
    logic [3:0]  seen_r;
    logic [3:0]  prev_r;
    always @(posedge clock) begin
        meas_valid <= 1'b0;
        for (int i = 0; i < 4; i++) begin
            prev_r[i] <= pwm[i];
            if (rst || !watch[i]) begin
                seen_r[i] <= 1'b0;
            end else if (pwm[i] && !prev_r[i]) begin
                // The first rise only opens a period, so a partial one is never reported.
                if (seen_r[i]) begin
                    meas_valid <= 1'b1;
                    meas       <= {i[1:0], len_r[i], hi_r[i]};
                end
                seen_r[i] <= 1'b1;
                len_r[i]  <= 16'h0001;
                hi_r[i]   <= 16'h0001;
            end else begin
                len_r[i] <= len_r[i] + 16'h0001;
                hi_r[i]  <= hi_r[i] + {15'h0000, pwm[i]};
            end
        end
    end
endmodule : pcu_load

// >>> tb/pcu_top_tb.sv
// Self-checking bench of the modulation block: register traffic, update timing, pins.
// Assumes the design files and the load model are compiled before it.
`include "pcu_map.svh"
module pcu_top_tb;
    timeunit 1ns;
    timeprecision 1ns;
    logic        clock = 1'b0;
    logic        rst = 1'b1;
    logic [3:0]  addr = 4'h0;
    logic [15:0] wdata = 16'h0000;
    logic        wr = 1'b0;
    logic        rd = 1'b0;
    logic [15:0] rdata;
    logic [3:0]  pwm_out;
    logic [3:0]  watch = 4'h0;
    logic        meas_valid;
    logic [33:0] meas;
    int          n_errors = 0;
    int          checked = 0;
    int          cycles = 0;
    logic [16:0] rq [$];
    logic [33:0] mq [$];
    logic        rd_d = 1'b0;
    logic [15:0] lfsr = 16'h0019;
    logic [15:0] v;
    logic [15:0] d;
    int          k;
    always #25 clock = ~clock;
    pcu_top dut (.clock(clock), .rst(rst), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
                 .pwm_out(pwm_out));
    pcu_load load (.clock(clock), .rst(rst), .pwm(pwm_out), .watch(watch), .meas_valid(meas_valid), .meas(meas));
    function logic [15:0] rnd();
        lfsr = {lfsr[14:0], lfsr[15] ^ lfsr[13] ^ lfsr[12] ^ lfsr[10]};
        return lfsr;
    endfunction : rnd
    task chk(input string name, input logic [33:0] exp, input logic [33:0] got);
        checked++;
        if (got !== exp) begin
            n_errors++;
            $display("[ERR] %s expected %h seen %h", name, exp, got);
        end
    endtask : chk
    task finish_test();
        if (n_errors == 0 && checked > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask : finish_test
    task wrr(input logic [3:0] a, input logic [15:0] dv);
        @(posedge clock);
        wr    <= 1'b1;
        addr  <= a;
        wdata <= dv;
        @(posedge clock);
        wr <= 1'b0;
    endtask : wrr
    // The note's top bit says whether the monitor compares this read.
    task rdr(input logic [3:0] a, input logic [16:0] note, output logic [15:0] val);
        rq.push_back(note);
        @(posedge clock);
        rd   <= 1'b1;
        addr <= a;
        @(posedge clock);
        rd <= 1'b0;
        #1 val = rdata;
    endtask : rdr
    // Waits for the count to enter the range after having been outside it.
    task poll(input logic [15:0] lo, input logic [15:0] hi);
        logic was;
        logic hit;
        was = 1'b1;
        hit = 1'b0;
        for (int j = 0; j < 600 && !hit; j++) begin
            rdr(`PCU_OFS_COUNT, 17'h00000, v);
            hit = v >= lo && v <= hi && !was;
            was = v >= lo && v <= hi;
        end
        chk("count_poll", 34'h1, {33'h0, hit});
    endtask : poll
    always @(posedge clock) begin
        logic [16:0] nt;
        if (rd_d) begin
            nt = rq.pop_front();
            if (nt[16]) begin
                chk("rdata", {18'h0, nt[15:0]}, {18'h0, rdata});
            end
        end
        if (meas_valid) begin
            if (mq.size() == 0) begin
                chk("meas_extra", 34'h0, meas);
            end else begin
                chk("meas", mq.pop_front(), meas);
            end
        end
        rd_d <= rd;
    end
    // Ceiling well above the roughly 750 cycles that the sequence needs.
    always @(posedge clock) begin
        cycles++;
        if (cycles == 20000) begin
            n_errors++;
            finish_test();
        end
    end
    initial begin
        repeat (4) @(posedge clock);
        rst <= 1'b0;
        rdr(`PCU_OFS_PERIOD, {1'b1, `PCU_RST_PERIOD}, v);
        rdr(`PCU_OFS_DUTY, {1'b1, `PCU_RST_DUTY}, v);
        rdr(`PCU_OFS_STATE, {1'b1, 16'h0000}, v);
        k = 10 + int'(rnd() % 16'h0006);
        wrr(k[3:0], rnd());
        rdr(k[3:0], {1'b1, 16'h0000}, v);
        d = 16'h0002 + rnd() % 16'h0003;
        wrr(`PCU_OFS_PERIOD, 16'h0005);
        wrr(`PCU_OFS_DUTY, d);
        mq.push_back({2'd0, 16'h0006, d});
        mq.push_back({2'd0, 16'h0005, d - 16'h0001});
        mq.push_back({2'd0, 16'h0005, d - 16'h0001});
        watch <= 4'h1;
        wrr(`PCU_OFS_ENABLE, 16'h0001);
        for (k = 0; k < 100 && mq.size() > 0; k++) @(posedge clock);
        chk("meas_left", 34'h0, 34'(mq.size()));
        watch <= 4'h0;
        rdr(`PCU_OFS_STATE, {1'b1, 16'h0001}, v);
        wrr(`PCU_OFS_DISABLE, 16'h0001);
        rdr(`PCU_OFS_STATE, {1'b1, 16'h0000}, v);
        rdr(`PCU_OFS_OUT, {1'b1, 16'h0000}, v);
        wrr(`PCU_OFS_SELECT, 16'h0001);
        wrr(`PCU_OFS_MODE, 16'h0033);
        rdr(`PCU_OFS_MODE, {1'b1, 16'h0033}, v);
        rdr(`PCU_OFS_SELECT, {1'b1, 16'h0001}, v);
        wrr(`PCU_OFS_PERIOD, 16'h0028);
        wrr(`PCU_OFS_DUTY, 16'h000A);
        wrr(`PCU_OFS_ENABLE, 16'h0002);
        poll(16'h0004, 16'h001E);
        wrr(`PCU_OFS_UPDATE, 16'h0014);
        rdr(`PCU_OFS_DUTY, {1'b1, 16'h000A}, v);
        poll(16'h0001, 16'h0001);
        rdr(`PCU_OFS_DUTY, {1'b1, 16'h0014}, v);
        rdr(`PCU_OFS_OUT, {1'b1, 16'h0000}, v);
        d = 16'h0002 + rnd() % 16'h0020;
        poll(16'h0001, 16'h0001);
        wrr(`PCU_OFS_UPDATE, d);
        rdr(`PCU_OFS_DUTY, {1'b1, d}, v);
        wrr(`PCU_OFS_DISABLE, 16'h0002);
        wrr(`PCU_OFS_SELECT, 16'h0002);
        wrr(`PCU_OFS_MODE, 16'h0000);
        rdr(`PCU_OFS_COUNT, {1'b1, 16'h0000}, v);
        wrr(`PCU_OFS_UPDATE, 16'h0021);
        rdr(`PCU_OFS_PERIOD, {1'b1, 16'h0021}, v);
        wrr(`PCU_OFS_PERIOD, 16'h0000);
        wrr(`PCU_OFS_UPDATE, 16'h0022);
        rdr(`PCU_OFS_PERIOD, {1'b1, 16'h0000}, v);
        wrr(`PCU_OFS_SELECT, 16'h0003);
        wrr(`PCU_OFS_MODE, 16'h00F0);
        wrr(`PCU_OFS_ENABLE, 16'h0008);
        wrr(`PCU_OFS_DISABLE, 16'h0008);
        rdr(`PCU_OFS_STATE, {1'b1, 16'h0008}, v);
        rdr(`PCU_OFS_OUT, {1'b1, 16'h0000}, v);
        finish_test();
    end
endmodule : pcu_top_tb
